// File: design/irbc_ctrl.sv
/*
 * internal rom/ram bank controller: two cpu data ports, a program line-fill port and one
 * peripheral port, arbitrated per bank and page.
 * assumes requestors on core_clk hold a request steady until granted; rom pages have no
 * write path here, so their contents must be preloaded by the surrounding system.
 */
// Functional notes
// - rom is two 256-bit pages, each four independent 64-bit banks.
// - ram is one 256-bit page of eight independent 32-bit banks.
// - rom page 1 decodes at byte 0x40000, page 0 at byte 0x0.
// - up to three of four requestors granted per cycle without bank conflict.
// - two cpu data ports, each up to 64 bits per access.
// - program fetch port returns a full 256-bit line.
// - one 32-bit peripheral port shared by dma engine and host port.
// - a line fill conflicts only with data accesses to the same page.
// - data accesses collide only when they hit the same bank of a page.
// - a line fill completes with a two-cycle penalty.
`timescale 1ns/1ps
`include "irbc_params.svh"

module irbc_ctrl
    import irbc_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         resetn,
    input  wire logic [1:0]   cpu_req,
    input  wire logic [1:0]   cpu_we,
    input  wire logic [63:0]  cpu_addr,
    input  wire logic [15:0]  cpu_be,
    input  wire logic [127:0] cpu_wdata,
    output logic      [1:0]   cpu_gnt,
    output logic      [1:0]   cpu_rvalid,
    output logic      [127:0] cpu_rdata,
    input  wire logic         pf_req,
    input  wire logic [31:0]  pf_addr,
    output logic              pf_gnt,
    output logic              pf_rvalid,
    output logic      [255:0] pf_rdata,
    input  wire logic         per_req,
    input  wire logic         per_we,
    input  wire logic [31:0]  per_addr,
    input  wire logic [3:0]   per_be,
    input  wire logic [31:0]  per_wdata,
    output logic              per_gnt,
    output logic              per_rvalid,
    output logic      [31:0]  per_rdata
);
    import irbc_pkg::*;

    // ------------------------------------------------------------
    // storage: each page 256 bits wide, banking is in the decode
    // ------------------------------------------------------------
    logic [255:0] mem [3] [1<<`IRBC_WORD_AW];

    typedef struct packed {
        irbc_fill_t   fst;
        logic [1:0]   fpg;
        logic [`IRBC_WORD_AW-1:0] frow;
        logic [1:0]   cpu_rv;
        logic         per_rv;
        logic         pf_rv;
    } irbc_state_t;

    irbc_state_t s_q;
    irbc_state_t s_d;

    function automatic irbc_page_t page_of(input logic [31:0] a);
        if (a >= `IRBC_ROM0_BASE && a < `IRBC_ROM1_BASE) begin
            return IRBC_PG_ROM0;
        end else if (a >= `IRBC_ROM1_BASE && a < `IRBC_ROM1_BASE + `IRBC_PAGE_SPAN) begin
            return IRBC_PG_ROM1;
        end else if (a >= `IRBC_RAM_BASE && a < `IRBC_RAM_BASE + `IRBC_PAGE_SPAN) begin
            return IRBC_PG_RAM;
        end
        return IRBC_PG_NONE;
    endfunction

    // bank index in 32-bit units of the row; rom banks span two of them
    function automatic logic [7:0] bank_mask(input logic [31:0] a, input logic wide);
        logic [7:0] m;
        m = 8'h00;
        if (page_of(a) == IRBC_PG_RAM) begin
            m[a[4:2]] = 1'b1;
            if (wide) begin
                m[a[4:2] | 3'h1] = 1'b1;
            end
        end else begin
            m[{a[4:3], 1'b0}]     = 1'b1;
            m[{a[4:3], 1'b0} + 1] = 1'b1;
        end
        return m;
    endfunction

    // ------------------------------------------------------------
    // arbitration: fill > cpu0 > cpu1 > peripheral
    // ------------------------------------------------------------
    irbc_page_t pg   [4];
    logic [7:0] bm   [4];
    logic [31:0] ca   [2];
    logic [3:0] req;
    logic [3:0] gnt;

    always_comb begin
        logic [7:0] used    [4];
        logic       pg_busy [4];
        logic [1:0] cnt;
        // sized for every page code so an unmapped request never indexes past the end
        used    = '{default: 8'h00};
        pg_busy = '{default: 1'b0};
        cnt     = 2'h0;
        ca[0]   = cpu_addr[31:0];
        ca[1]   = cpu_addr[63:32];
        pg[0] = page_of(cpu_addr[31:0]);
        pg[1] = page_of(cpu_addr[63:32]);
        pg[2] = page_of(per_addr);
        pg[3] = page_of(pf_addr);
        bm[0] = bank_mask(cpu_addr[31:0], 1'b1);
        bm[1] = bank_mask(cpu_addr[63:32], 1'b1);
        bm[2] = bank_mask(per_addr, 1'b0);
        bm[3] = 8'hFF;
        req = {pf_req && pg[3] != IRBC_PG_NONE && s_q.fst == IRBC_F_IDLE,
               per_req && pg[2] != IRBC_PG_NONE,
               cpu_req[1] && pg[1] != IRBC_PG_NONE,
               cpu_req[0] && pg[0] != IRBC_PG_NONE};
        // an in-flight fill keeps its page off limits until the line is read
        if (s_q.fst != IRBC_F_IDLE) begin
            pg_busy[s_q.fpg] = 1'b1;
        end
        gnt = 4'h0;
        if (req[3] && !pg_busy[pg[3]]) begin
            gnt[3] = 1'b1;
            pg_busy[pg[3]] = 1'b1;
            cnt = cnt + 2'h1;
        end
        for (int i = 0; i < 3; i++) begin
            if (req[i] && cnt != 2'h3 && !pg_busy[pg[i]] && (used[pg[i]] & bm[i]) == 8'h00) begin
                gnt[i] = 1'b1;
                used[pg[i]] = used[pg[i]] | bm[i];
                cnt = cnt + 2'h1;
            end
        end
    end

    assign cpu_gnt = gnt[1:0];
    assign per_gnt = gnt[2];
    assign pf_gnt  = gnt[3];

    // ------------------------------------------------------------
    // line fill sequencer and next state
    // ------------------------------------------------------------
    always_comb begin
        s_d        = s_q;
        s_d.cpu_rv = gnt[1:0];
        s_d.per_rv = gnt[2];
        s_d.pf_rv  = 1'b0;
        unique case (s_q.fst)
            IRBC_F_IDLE: begin
                if (gnt[3]) begin
                    s_d.fst  = IRBC_F_WAIT;
                    s_d.fpg  = pg[3];
                    s_d.frow = pf_addr[`IRBC_WORD_AW+4:5];
                end
            end
            IRBC_F_WAIT: begin
                s_d.fst   = IRBC_F_IDLE;
                s_d.pf_rv = 1'b1;
            end
            IRBC_F_DONE: begin
                s_d.fst = IRBC_F_IDLE;
            end
            default: begin
                s_d.fst = IRBC_F_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{fst: IRBC_F_IDLE, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign cpu_rvalid = s_q.cpu_rv;
    assign per_rvalid = s_q.per_rv;
    assign pf_rvalid  = s_q.pf_rv;

    // ------------------------------------------------------------
    // memory access: writes lane-masked, reads registered
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (gnt[i] && cpu_we[i] && pg[i] == IRBC_PG_RAM) begin
                for (int b = 0; b < 8; b++) begin
                    if (cpu_be[8*i+b]) begin
                        mem[pg[i]][ca[i][`IRBC_WORD_AW+4:5]][{ca[i][4:3], 6'h00} + 8*b +: 8]
                            <= cpu_wdata[64*i + 8*b +: 8];
                    end
                end
            end
            if (gnt[i]) begin
                cpu_rdata[64*i +: 64]
                    <= mem[pg[i]][ca[i][`IRBC_WORD_AW+4:5]][{ca[i][4:3], 6'h00} +: 64];
            end
        end
        if (gnt[2]) begin
            if (per_we && pg[2] == IRBC_PG_RAM) begin
                for (int b = 0; b < 4; b++) begin
                    if (per_be[b]) begin
                        mem[pg[2]][per_addr[`IRBC_WORD_AW+4:5]][{per_addr[4:2], 5'h00} + 8*b +: 8]
                            <= per_wdata[8*b +: 8];
                    end
                end
            end
            per_rdata <= mem[pg[2]][per_addr[`IRBC_WORD_AW+4:5]][{per_addr[4:2], 5'h00} +: 32];
        end
        if (s_q.fst == IRBC_F_WAIT) begin
            pf_rdata <= mem[s_q.fpg][s_q.frow];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_three_max: assert property (@(posedge core_clk) disable iff (!resetn)
        $countones(gnt) <= 3) else $error("more than three grants");
    a_fill_penalty: assert property (@(posedge core_clk) disable iff (!resetn)
        pf_gnt |-> ##2 pf_rvalid) else $error("line fill not back in two cycles");
    a_fill_page: assert property (@(posedge core_clk) disable iff (!resetn)
        (pf_gnt && gnt[0]) |-> pg[0] != pg[3]) else $error("fill shares page with cpu0");
    a_bank_clash: assert property (@(posedge core_clk) disable iff (!resetn)
        (gnt[0] && gnt[1] && pg[0] == pg[1]) |-> (bm[0] & bm[1]) == 8'h00)
        else $error("same bank granted twice");
    a_cpu_data: assert property (@(posedge core_clk) disable iff (!resetn)
        gnt[0] |=> cpu_rvalid[0]) else $error("cpu0 answer missing");
    a_per_data: assert property (@(posedge core_clk) disable iff (!resetn)
        gnt[2] |=> per_rvalid) else $error("peripheral answer missing");
    // cpu0 may only lose to a fill that takes or still holds its page
    a_prio_cpu0: assert property (@(posedge core_clk) disable iff (!resetn)
        (req[0] && !(pf_gnt && pg[3] == pg[0]) && !(s_q.fst == IRBC_F_WAIT && s_q.fpg == pg[0]))
        |-> gnt[0]) else $error("cpu0 lost without fill");
    a_rom_pages: assert property (@(posedge core_clk) disable iff (!resetn)
        (pf_req && pf_addr == `IRBC_ROM1_BASE) |-> pg[3] == IRBC_PG_ROM1)
        else $error("rom page 1 decode wrong");
    a_fill_line: assert property (@(posedge core_clk) disable iff (!resetn)
        pf_rvalid |-> $past(s_q.fst) == IRBC_F_WAIT) else $error("fill out of sequence");
    c_three_way: cover property (@(posedge core_clk) $countones(gnt) == 3);
    c_clash: cover property (@(posedge core_clk) req[0] && req[1] && !gnt[1]);
    c_fill_data: cover property (@(posedge core_clk) pf_gnt && gnt[0]);
endmodule

// File: design/irbc_params.svh
/*
 * constants for the internal rom/ram bank controller: page bases, bank geometry, fill timing.
 * assumes byte addressing from every requestor; included by its bare name.
 */
`ifndef IRBC_PARAMS_SVH
`define IRBC_PARAMS_SVH

// ------------------------------------------------------------
// address map and bank geometry
// ------------------------------------------------------------
`define IRBC_ROM0_BASE     32'h0000_0000
`define IRBC_ROM1_BASE     32'h0004_0000
`define IRBC_RAM_BASE      32'h1000_0000
`define IRBC_PAGE_SPAN     32'h0004_0000
`define IRBC_ROM_BANKS     4
`define IRBC_RAM_BANKS     8
`define IRBC_WORD_AW       13
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define IRBC_FILL_PENALTY  2

`endif

// File: design/irbc_pkg.sv
/*
 * types for the bank controller.
 * assumes nothing beyond the params header.
 */
package irbc_pkg;
    typedef enum logic [1:0] {
        IRBC_PG_ROM0 = 2'h0,
        IRBC_PG_ROM1 = 2'h1,
        IRBC_PG_RAM  = 2'h2,
        IRBC_PG_NONE = 2'h3
    } irbc_page_t;

    typedef enum logic [2:0] {
        IRBC_F_IDLE = 3'h1,
        IRBC_F_WAIT = 3'h2,
        IRBC_F_DONE = 3'h4
    } irbc_fill_t;
endpackage

// File: test/irbc_per_model.sv
/*
 * peripheral-side requestor model standing for the dma engine or the host port.
 * assumes irbc_ctrl grants in the request cycle and answers every access one cycle later.
 */
`timescale 1ns/1ps
module irbc_per_model (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        go,
    input  wire logic        we,
    input  wire logic [31:0] addr,
    input  wire logic [3:0]  be,
    input  wire logic [31:0] wdata,
    output logic             per_req,
    output logic             per_we,
    output logic [31:0]      per_addr,
    output logic [3:0]       per_be,
    output logic [31:0]      per_wdata,
    input  wire logic        per_gnt,
    input  wire logic        per_rvalid,
    input  wire logic [31:0] per_rdata,
    output logic [31:0]      rd_q,
    output logic             done_q
);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            per_req   <= 1'b0;
            per_we    <= 1'b0;
            per_addr  <= 32'h0000_0000;
            per_be    <= 4'h0;
            per_wdata <= 32'h0000_0000;
            rd_q      <= 32'h0000_0000;
            done_q    <= 1'b0;
        end else begin
            // one done pulse per access: reads and writes alike answer a cycle after grant
            done_q <= per_rvalid;
            if (per_rvalid) begin
                rd_q <= per_rdata;
            end
            // released address and write-data lines go inverted so a stale value is never read as valid
            if (per_req & per_gnt) begin
                per_req   <= 1'b0;
                per_addr  <= ~per_addr;
                per_wdata <= ~per_wdata;
            end else if (go & !per_req) begin
                per_req   <= 1'b1;
                per_we    <= we;
                per_addr  <= addr;
                per_be    <= be;
                per_wdata <= wdata;
            end
        end
    end
endmodule

// File: test/internal_rom_ram_bank_controller_test.sv
/*
 * self-checking bench for irbc_ctrl: cpu and fill ports driven here, peripheral port by a model.
 * assumes irbc_per_model is compiled first; ram holds nothing useful before it is written.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] %0t mismatch", $time); end end
module internal_rom_ram_bank_controller_test;
    logic         core_clk  = 1'b0;
    logic         resetn    = 1'b0;
    logic [1:0]   cpu_req   = 2'h0;
    logic [1:0]   cpu_we    = 2'h0;
    logic [63:0]  cpu_addr  = 64'h0;
    logic [15:0]  cpu_be    = 16'h0;
    logic [127:0] cpu_wdata = 128'h0;
    logic         pf_req    = 1'b0;
    logic [31:0]  pf_addr   = 32'h0;
    logic         go        = 1'b0;
    logic         pwe       = 1'b0;
    logic [31:0]  paddr     = 32'h0;
    logic [31:0]  pdata     = 32'h0;
    logic [3:0]   pbe       = 4'h0;
    logic [1:0]   cpu_gnt, cpu_rvalid;
    logic [127:0] cpu_rdata;
    logic [255:0] pf_rdata;
    logic         pf_gnt, pf_rvalid, per_req, per_we, per_gnt, per_rvalid, done_q;
    logic [31:0]  per_addr, per_wdata, per_rdata, rd_q;
    logic [3:0]   per_be;
    int           err_count = 0;
    int           n_tests   = 0;

    always #4 core_clk = ~core_clk;

    irbc_ctrl u_irbc_ctrl (.core_clk, .resetn, .cpu_req, .cpu_we, .cpu_addr, .cpu_be, .cpu_wdata,
        .cpu_gnt, .cpu_rvalid, .cpu_rdata, .pf_req, .pf_addr, .pf_gnt, .pf_rvalid, .pf_rdata,
        .per_req, .per_we, .per_addr, .per_be, .per_wdata, .per_gnt, .per_rvalid, .per_rdata);
    irbc_per_model u_irbc_per_model (.core_clk, .resetn, .go, .we(pwe), .addr(paddr), .be(pbe),
        .wdata(pdata), .per_req, .per_we, .per_addr, .per_be, .per_wdata, .per_gnt, .per_rvalid,
        .per_rdata, .rd_q, .done_q);

    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    task automatic cpu_set(input int i, input logic w, input logic [31:0] a, input logic [63:0] d);
        cpu_req[i]          <= 1'b1;
        cpu_we[i]           <= w;
        cpu_addr[32*i+:32]  <= a;
        cpu_be[8*i+:8]      <= 8'hFF;
        cpu_wdata[64*i+:64] <= d;
    endtask

    task automatic per_op(input logic w, input logic [31:0] a, input logic [3:0] b,
                          input logic [31:0] d);
        int k;
        go    <= 1'b1;
        pwe   <= w;
        paddr <= a;
        pbe   <= b;
        pdata <= d;
        @(posedge core_clk);
        go <= 1'b0;
        @(negedge core_clk);
        for (k = 0; k < 20 && done_q !== 1'b1; k++) @(negedge core_clk);
        `CHK(done_q, 1'b1)
        @(posedge core_clk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_ram;
        @(posedge core_clk);
        cpu_set(0, 1'b1, 32'h1000_0008, 64'h1122_3344_5566_7788);
        @(negedge core_clk);
        `CHK(cpu_gnt, 2'b01)
        @(posedge core_clk);
        cpu_req <= 2'h0;
        per_op(1'b1, 32'h1000_000C, 4'h2, 32'h0000_AB00);
        per_op(1'b0, 32'h1000_0008, 4'hF, 32'h0);
        `CHK(rd_q, 32'h5566_7788)
        cpu_set(1, 1'b0, 32'h1000_0008, 64'h0);
        @(posedge core_clk);
        cpu_req <= 2'h0;
        @(negedge core_clk);
        `CHK(cpu_rvalid, 2'b10)
        `CHK(cpu_rdata[127:64], 64'h1122_AB44_5566_7788)
        @(posedge core_clk);
        cpu_set(0, 1'b0, 32'h1000_000C, 64'h0);
        @(posedge core_clk);
        cpu_req <= 2'h0;
        @(negedge core_clk);
        `CHK({cpu_rvalid[0], cpu_rdata[63:0]}, {1'b1, 64'h1122_AB44_5566_7788})
    endtask

    task automatic t_fill;
        @(posedge core_clk);
        pf_req  <= 1'b1;
        pf_addr <= 32'h1000_0000;
        cpu_set(0, 1'b0, 32'h0000_0000, 64'h0);
        cpu_set(1, 1'b0, 32'h1000_0010, 64'h0);
        @(negedge core_clk);
        `CHK({pf_gnt, cpu_gnt}, 3'b101)
        @(posedge core_clk);
        pf_req  <= 1'b0;
        cpu_req <= 2'b10;
        @(negedge core_clk);
        `CHK({pf_rvalid, cpu_gnt}, 3'b000)
        @(negedge core_clk);
        `CHK({pf_rvalid, cpu_gnt}, 3'b110)
        `CHK(pf_rdata[127:64], 64'h1122_AB44_5566_7788)
        @(posedge core_clk);
        cpu_req <= 2'h0;
    endtask

    task automatic t_conf;
        @(posedge core_clk);
        cpu_set(0, 1'b0, 32'h1000_0000, 64'h0);
        cpu_set(1, 1'b0, 32'h1000_0000, 64'h0);
        @(negedge core_clk);
        `CHK(cpu_gnt, 2'b01)
        @(posedge core_clk);
        cpu_req <= 2'b10;
        @(negedge core_clk);
        `CHK(cpu_gnt, 2'b10)
        @(posedge core_clk);
        cpu_req <= 2'h0;
        go      <= 1'b1;
        pwe     <= 1'b0;
        paddr   <= 32'h1000_0008;
        @(posedge core_clk);
        go      <= 1'b0;
        pf_req  <= 1'b1;
        pf_addr <= 32'h0004_0000;
        cpu_set(0, 1'b0, 32'h1000_0000, 64'h0);
        cpu_set(1, 1'b0, 32'h1000_0010, 64'h0);
        @(negedge core_clk);
        `CHK({pf_gnt, cpu_gnt, per_gnt}, 4'b1110)
        @(posedge core_clk);
        pf_req  <= 1'b0;
        cpu_req <= 2'h0;
        @(negedge core_clk);
        `CHK(per_gnt, 1'b1)
        @(posedge core_clk);
        // the unmapped gap above the second rom page must never be served
        cpu_set(1, 1'b0, 32'h0008_0000, 64'h0);
        repeat (3) @(negedge core_clk);
        `CHK(cpu_gnt, 2'b00)
        `CHK(rd_q, 32'h5566_7788)
        @(posedge core_clk);
        cpu_req <= 2'h0;
    endtask

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        t_ram();
        t_fill();
        t_conf();
        end_sim();
    end

    initial begin
        repeat (3000) @(posedge core_clk);
        err_count++;
        end_sim();
    end
endmodule
